// ### frp_defs.vh
// constants for the flash readout protection policy block
// assumes one 25 MHz clock and a synchronous active-high reset
`ifndef FRP_DEFS_VH
`define FRP_DEFS_VH

// ----------------------------------------
// protection levels, ordered for compare
// ----------------------------------------
`define FRP_LVL_0     2'h0
`define FRP_LVL_05    2'h1
`define FRP_LVL_1     2'h2
`define FRP_LVL_2     2'h3
`define FRP_LVL_RST   2'h3

// ----------------------------------------
// target areas
// ----------------------------------------
`define FRP_AREA_MAIN   3'h0
`define FRP_AREA_SYSMEM 3'h1
`define FRP_AREA_OPT    3'h2
`define FRP_AREA_OTP    3'h3
`define FRP_AREA_BKPREG 3'h4
`define FRP_AREA_BKPRAM 3'h5

// ----------------------------------------
// operations and masters
// ----------------------------------------
`define FRP_OP_READ   2'h0
`define FRP_OP_WRITE  2'h1
`define FRP_OP_ERASE  2'h2
`define FRP_MST_USER  2'h0
`define FRP_MST_DEBUG 2'h1
`define FRP_MST_RAMBT 2'h2
`define FRP_MST_BOOTL 2'h3

// ----------------------------------------
// geometry
// ----------------------------------------
`define FRP_PAGES_PER_BANK 32
`define FRP_PAGE_BYTES     8192
`define FRP_PREFETCH_W     128
`define FRP_OTP_BYTES      512

`endif

// ### frp_policy.v
// access policy for a dual-bank flash with readout protection levels
// assumes option byte values and engine status come from logic on i_clk;
// the debugger-present pin is asynchronous and is synchronised here
`timescale 1ns/1ns
`include "frp_defs.vh"

module frp_policy #(
    parameter PAGE_BITS = 5,
    parameter PAGE_LSB  = 13,
    parameter ADDR_W    = 19,
    parameter OTP_IDX_W = 5
) (
    input  wire                   i_clk,
    input  wire                   i_reset,
    // option byte values; level, extension, key, password and swap latched once after reset, write-protect ranges used live
    input  wire [1:0]             i_ob_level,
    input  wire                   i_ob_sec_ext_en,
    input  wire                   i_ob_key_configured,
    input  wire                   i_ob_pwd_required,
    input  wire                   i_ob_swap_bank,
    input  wire [4*PAGE_BITS-1:0] i_wrp_start,
    input  wire [4*PAGE_BITS-1:0] i_wrp_end,
    input  wire [3:0]             i_wrp_en,
    input  wire                   i_debug_pin,
    // access request
    input  wire                   i_req_valid,
    input  wire [2:0]             i_req_area,
    input  wire [1:0]             i_req_op,
    input  wire [1:0]             i_req_master,
    input  wire                   i_req_secure,
    input  wire [ADDR_W-1:0]      i_req_addr,
    output wire                   o_req_ready,
    output reg                    o_resp_valid,
    output reg                    o_resp_error,
    output reg                    o_resp_bank,
    output reg  [PAGE_BITS-1:0]   o_resp_page,
    input  wire [1:0]             i_bank_busy,
    // refusal status
    output reg                    o_refused,
    input  wire                   i_refused_clear,
    // option programming
    input  wire                   i_opt_start,
    input  wire                   i_opt_swap_only,
    input  wire                   i_opt_swap_val,
    input  wire [1:0]             i_opt_level,
    input  wire                   i_auth_ok,
    input  wire                   i_auth_from_debug,
    output reg                    o_opt_done,
    output reg                    o_opt_error,
    output reg                    o_wipe_flash,
    output reg                    o_wipe_backup,
    output reg                    o_wipe_sram,
    input  wire                   i_wipe_done,
    output reg  [1:0]             o_level,
    output reg                    o_sec_ext_en,
    output reg                    o_swap_bank,
    output wire                   o_debug_enable,
    // prefetch and ecc report
    input  wire                   i_prefetch_en,
    output reg                    o_prefetch_en,
    input  wire                   i_ecc_valid,
    input  wire                   i_ecc_single,
    input  wire                   i_ecc_double,
    input  wire [ADDR_W-1:0]      i_ecc_addr,
    input  wire                   i_ecc_clear,
    output reg                    o_ecc_corrected,
    output reg                    o_ecc_double,
    output reg  [ADDR_W-1:0]      o_ecc_fail_addr
);

    // ----------------------------------------
    // state machine
    // ----------------------------------------
    localparam ST_LOAD = 2'h0;
    localparam ST_IDLE = 2'h1;
    localparam ST_WIPE = 2'h2;

    localparam OTP_WORDS = 1 << OTP_IDX_W;

    reg  [1:0]           state;
    reg                  key_cfg;
    reg                  pwd_req;
    reg                  dbg_meta;
    reg                  dbg_sync;
    reg  [OTP_WORDS-1:0] otp_used;
    reg                  deny;
    reg                  opt_bad;
    reg                  opt_wipe;

    wire                 req_bank = i_req_addr[ADDR_W-1];
    wire [PAGE_BITS-1:0] req_page = i_req_addr[PAGE_LSB +: PAGE_BITS];
    // an otp location is a 16-byte unit: 32 of them cover 512 bytes
    wire [OTP_IDX_W-1:0] otp_idx  = i_req_addr[4 +: OTP_IDX_W];
    wire [3:0]           wrp_hit;
    wire                 nonuser;
    wire                 take;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // write, erase and the spare code all alter the target
    function is_change;
        input [1:0] op;
        begin
            is_change = (op != `FRP_OP_READ);
        end
    endfunction

    // level-1 gate shared by areas that close to foreign masters
    function is_level_one;
        input [1:0] lvl;
        begin
            is_level_one = (lvl == `FRP_LVL_1);
        end
    endfunction

    // ----------------------------------------
    // debugger presence
    // ----------------------------------------
    always @(posedge i_clk) begin
        if (i_reset) begin
            dbg_meta <= 1'b0;
            dbg_sync <= 1'b0;
        end else begin
            dbg_meta <= i_debug_pin;
            dbg_sync <= dbg_meta;
        end
    end

    // a user master with a debugger attached counts as debug; at level 2
    // the debug port is shut, so a stray presence level must not lock out
    // the application running from flash
    assign nonuser = (i_req_master != `FRP_MST_USER)
                     || (dbg_sync && o_debug_enable);
    assign o_debug_enable = (o_level != `FRP_LVL_2);

    // ----------------------------------------
    // write-protect areas, two per bank
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_wrp
            wire [PAGE_BITS-1:0] lo = i_wrp_start[g*PAGE_BITS +: PAGE_BITS];
            wire [PAGE_BITS-1:0] hi = i_wrp_end[g*PAGE_BITS +: PAGE_BITS];
            // areas 0 and 1 guard bank 0, areas 2 and 3 bank 1
            wire                 bank_g = (g >= 2) ? 1'b1 : 1'b0;
            assign wrp_hit[g] = i_wrp_en[g] && (req_bank == bank_g)
                                && (req_page >= lo) && (req_page <= hi);
        end
    endgenerate

    // ----------------------------------------
    // access decision
    // ----------------------------------------
    // main flash access to a busy bank waits; the other bank runs on
    assign o_req_ready = (state == ST_IDLE)
                         && !((i_req_area == `FRP_AREA_MAIN)
                              && i_bank_busy[req_bank]);
    assign take = i_req_valid && o_req_ready;

    always @* begin
        deny = 1'b0;
        // level 2 shuts out every debug, ram boot and bootloader master
        if ((o_level == `FRP_LVL_2) && nonuser)
            deny = 1'b1;
        // with the security extension the sram boot path is closed at level 1
        if ((o_level == `FRP_LVL_1) && o_sec_ext_en
            && (i_req_master == `FRP_MST_RAMBT))
            deny = 1'b1;
        if ((o_level == `FRP_LVL_05) && nonuser && i_req_secure)
            deny = 1'b1;
        case (i_req_area)
            `FRP_AREA_MAIN: begin
                if (is_level_one(o_level) && nonuser
                    && !(o_sec_ext_en && !i_req_secure
                         && (i_req_master != `FRP_MST_RAMBT)))
                    deny = 1'b1;
                if (is_change(i_req_op) && (|wrp_hit))
                    deny = 1'b1;
            end
            `FRP_AREA_SYSMEM: begin
                if (is_change(i_req_op))
                    deny = 1'b1;
            end
            `FRP_AREA_OPT: begin
                if (is_change(i_req_op))
                    deny = 1'b1;
            end
            `FRP_AREA_OTP: begin
                if (i_req_op == `FRP_OP_ERASE)
                    deny = 1'b1;
                if ((i_req_op == `FRP_OP_WRITE) && otp_used[otp_idx])
                    deny = 1'b1;
            end
            `FRP_AREA_BKPREG, `FRP_AREA_BKPRAM: begin
                if (i_req_op == `FRP_OP_ERASE)
                    deny = 1'b1;
                if (is_level_one(o_level) && nonuser)
                    deny = 1'b1;
            end
            default: begin
                deny = 1'b1;
            end
        endcase
        // user masters booted from flash pass every level gate above untouched
        // at level 2, and at level 1 while no debugger is attached; the area rules still apply
    end

    // ----------------------------------------
    // option programming check
    // ----------------------------------------
    always @* begin
        opt_bad  = 1'b0;
        opt_wipe = 1'b0;
        if (!i_opt_swap_only) begin
            if (o_level == `FRP_LVL_2) begin
                // no key means level 2 can never be left
                if (!(key_cfg && (i_opt_level == `FRP_LVL_1)
                      && i_auth_ok && i_auth_from_debug))
                    opt_bad = 1'b1;
            end
            if ((i_opt_level == `FRP_LVL_05) && !o_sec_ext_en)
                opt_bad = 1'b1;
            // raising the level needs no password
            if (is_level_one(o_level) && (i_opt_level < `FRP_LVL_1)
                && pwd_req && !i_auth_ok)
                opt_bad = 1'b1;
            if ((o_level == `FRP_LVL_1) && (i_opt_level == `FRP_LVL_0))
                opt_wipe = 1'b1;
        end
    end

    // ----------------------------------------
    // level, option and access state
    // ----------------------------------------
    always @(posedge i_clk) begin
        if (i_reset) begin
            state         <= ST_LOAD;
            o_level       <= `FRP_LVL_RST;
            o_sec_ext_en  <= 1'b0;
            o_swap_bank   <= 1'b0;
            key_cfg       <= 1'b0;
            pwd_req       <= 1'b0;
            o_opt_done    <= 1'b0;
            o_opt_error   <= 1'b0;
            o_wipe_flash  <= 1'b0;
            o_wipe_backup <= 1'b0;
            o_wipe_sram   <= 1'b0;
            o_resp_valid  <= 1'b0;
            o_resp_error  <= 1'b0;
            o_resp_bank   <= 1'b0;
            o_resp_page   <= {PAGE_BITS{1'b0}};
            o_refused     <= 1'b0;
            otp_used      <= {OTP_WORDS{1'b0}};
        end else begin
            o_opt_done   <= 1'b0;
            o_opt_error  <= 1'b0;
            o_resp_valid <= take;
            o_resp_error <= take && deny;
            if (take) begin
                o_resp_bank <= req_bank;
                o_resp_page <= req_page;
            end
            // a new refusal wins over a clear in the same cycle
            if (take && deny)
                o_refused <= 1'b1;
            else if (i_refused_clear)
                o_refused <= 1'b0;
            // only granted writes burn an otp location
            if (take && !deny && (i_req_area == `FRP_AREA_OTP)
                && (i_req_op == `FRP_OP_WRITE))
                otp_used[otp_idx] <= 1'b1;
            case (state)
                ST_LOAD: begin
                    // values loaded here; level and swap can later change through option programming, the rest held until the next reset
                    o_level      <= i_ob_level;
                    o_sec_ext_en <= i_ob_sec_ext_en;
                    key_cfg      <= i_ob_key_configured;
                    pwd_req      <= i_ob_pwd_required;
                    o_swap_bank  <= i_ob_swap_bank;
                    state        <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (i_opt_start) begin
                        if (opt_bad) begin
                            o_opt_error <= 1'b1;
                        end else if (i_opt_swap_only) begin
                            o_swap_bank <= i_opt_swap_val;
                            o_opt_done  <= 1'b1;
                        end else if (opt_wipe) begin
                            o_wipe_flash  <= 1'b1;
                            o_wipe_backup <= 1'b1;
                            o_wipe_sram   <= 1'b1;
                            state         <= ST_WIPE;
                        end else begin
                            o_level    <= i_opt_level;
                            o_opt_done <= 1'b1;
                        end
                    end
                end
                ST_WIPE: begin
                    // level stays 1 until every wipe has finished
                    if (i_wipe_done) begin
                        o_wipe_flash  <= 1'b0;
                        o_wipe_backup <= 1'b0;
                        o_wipe_sram   <= 1'b0;
                        o_level       <= `FRP_LVL_0;
                        o_opt_done    <= 1'b1;
                        state         <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // prefetch enable and ecc report
    // ----------------------------------------
    // correction itself happens in the array read path; this keeps the record
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_prefetch_en   <= 1'b0;
            o_ecc_corrected <= 1'b0;
            o_ecc_double    <= 1'b0;
            o_ecc_fail_addr <= {ADDR_W{1'b0}};
        end else begin
            o_prefetch_en <= i_prefetch_en;
            // only the newest failing address is kept; software that reads
            // late sees an older one overwritten
            if (i_ecc_valid && (i_ecc_single || i_ecc_double))
                o_ecc_fail_addr <= i_ecc_addr;
            if (i_ecc_valid && i_ecc_single)
                o_ecc_corrected <= 1'b1;
            else if (i_ecc_clear)
                o_ecc_corrected <= 1'b0;
            if (i_ecc_valid && i_ecc_double)
                o_ecc_double <= 1'b1;
            else if (i_ecc_clear)
                o_ecc_double <= 1'b0;
        end
    end

endmodule // frp_policy

// ### frp_master_model.sv
// far-side model: debugger presence, password answer and wipe engine
// assumes commands from the bench and wipe strobes on the same clock
`timescale 1ns/1ns
module frp_master_model (
    input  wire       i_clk,
    input  wire       i_attach,
    input  wire       i_pwd,
    input  wire       i_wipe,
    input  wire [3:0] i_delay,
    output reg        o_debug_pin,
    output reg        o_auth_ok,
    output reg        o_auth_from_debug,
    output reg        o_wipe_done
);
    reg [3:0] cnt = 4'h0;

    initial begin
        o_debug_pin = 1'b0;
        o_auth_ok = 1'b0;
        o_auth_from_debug = 1'b0;
        o_wipe_done = 1'b0;
    end

    always @(posedge i_clk) begin
        o_debug_pin <= i_attach;
        o_auth_ok <= i_pwd;
        o_auth_from_debug <= i_pwd && i_attach;
        // slow wipe: flash, backup registers and sram cleared together
        cnt <= i_wipe ? cnt + 4'h1 : 4'h0;
        o_wipe_done <= i_wipe && (cnt == i_delay);
    end
endmodule // frp_master_model

// ### frp_policy_assertions.sv
// concurrent checks on the protection policy ports
// assumes binding into frp_policy, one clock, sync active-high reset
`timescale 1ns/1ns
`include "frp_defs.vh"
module frp_policy_chk (
    input wire        i_clk,
    input wire        i_reset,
    input wire        i_req_valid,
    input wire [2:0]  i_req_area,
    input wire [1:0]  i_req_op,
    input wire [18:0] i_req_addr,
    input wire [1:0]  i_bank_busy,
    input wire        o_req_ready,
    input wire        o_resp_valid,
    input wire        o_resp_error,
    input wire        o_refused,
    input wire [1:0]  o_level,
    input wire        o_debug_enable,
    input wire        o_wipe_flash,
    input wire        o_wipe_backup,
    input wire        o_wipe_sram,
    input wire        o_opt_done,
    input wire        i_ecc_valid,
    input wire        i_ecc_double,
    input wire        o_ecc_double
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    wire take = i_req_valid && o_req_ready;
    wire wr = i_req_op != `FRP_OP_READ;

    property p_answer; take |=> o_resp_valid; endproperty
    a_answer: assert property (p_answer)
        else $error("no answer after take");
    property p_quiet; !take |=> !o_resp_valid; endproperty
    a_quiet: assert property (p_quiet)
        else $error("answer without take");
    property p_sysmem; take && wr && i_req_area == `FRP_AREA_SYSMEM |=> o_resp_error; endproperty
    a_sysmem: assert property (p_sysmem)
        else $error("system memory change accepted");
    property p_optwr; take && wr && i_req_area == `FRP_AREA_OPT |=> o_resp_error; endproperty
    a_optwr: assert property (p_optwr)
        else $error("direct option write accepted");
    property p_flag; o_resp_valid && o_resp_error |-> o_refused; endproperty
    a_flag: assert property (p_flag)
        else $error("refusal without flag");
    property p_nodbg; o_level == `FRP_LVL_2 |-> !o_debug_enable; endproperty
    a_nodbg: assert property (p_nodbg)
        else $error("debug open at top level");
    property p_stall;
        i_req_valid && i_req_area == `FRP_AREA_MAIN && i_bank_busy[i_req_addr[18]]
            |-> !o_req_ready;
    endproperty
    a_stall: assert property (p_stall)
        else $error("busy bank access taken");
    property p_wipe; o_wipe_flash |-> o_wipe_backup && o_wipe_sram; endproperty
    a_wipe: assert property (p_wipe)
        else $error("partial wipe");
    property p_wipe_end; $fell(o_wipe_flash) |-> o_level == `FRP_LVL_0 && o_opt_done; endproperty
    a_wipe_end: assert property (p_wipe_end)
        else $error("wipe ended without level 0");
    property p_level; $changed(o_level) |-> o_opt_done || $past(i_reset, 2); endproperty
    a_level: assert property (p_level)
        else $error("level moved outside programming");
    property p_ecc; i_ecc_valid && i_ecc_double |=> o_ecc_double; endproperty
    a_ecc: assert property (p_ecc)
        else $error("double error not flagged");
    c_wipe: cover property (o_wipe_flash ##1 !o_wipe_flash);
    c_refuse: cover property (o_resp_valid && o_resp_error);
    c_stall: cover property (i_req_valid && !o_req_ready);
endmodule // frp_policy_chk

bind frp_policy frp_policy_chk i_frp_policy_chk (.*);

// ### frp_policy_tb.sv
// self-checking bench for the readout protection policy
// assumes frp_policy with default parameters and the far-side model
`timescale 1ns/1ns
`include "frp_defs.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module frp_policy_tb;
    logic i_clk = 0, i_reset = 1, i_ob_sec_ext_en = 0, i_ob_key_configured = 0;
    logic i_ob_pwd_required = 0, i_ob_swap_bank = 0, i_req_valid = 0, i_req_secure = 0;
    logic i_refused_clear = 0, i_opt_start = 0, i_opt_swap_only = 0, i_opt_swap_val = 0;
    logic i_prefetch_en = 0, i_ecc_valid = 0, i_ecc_single = 0, i_ecc_double = 0;
    logic i_ecc_clear = 0, attach = 0, pwd = 0;
    logic [1:0]  i_ob_level = 0, i_req_op = 0, i_req_master = 0, i_bank_busy = 0;
    logic [1:0]  i_opt_level = 0, o_level;
    logic [2:0]  i_req_area = 0;
    logic [3:0]  i_wrp_en = 0;
    logic [4:0]  o_resp_page;
    logic [18:0] i_req_addr = 0, i_ecc_addr = 0, o_ecc_fail_addr;
    logic [19:0] i_wrp_start = 0, i_wrp_end = 0;
    logic o_req_ready, o_resp_valid, o_resp_error, o_resp_bank, o_refused, o_opt_done;
    logic o_opt_error, o_wipe_flash, o_wipe_backup, o_wipe_sram, o_sec_ext_en, o_swap_bank;
    logic o_debug_enable, o_prefetch_en, o_ecc_corrected, o_ecc_double;
    wire  i_debug_pin, i_auth_ok, i_auth_from_debug, i_wipe_done;
    integer error_cnt = 0, num_checks = 0, m;

    frp_policy i_frp_policy (.*);
    frp_master_model i_frp_master_model (.i_clk(i_clk), .i_attach(attach), .i_pwd(pwd),
        .i_wipe(o_wipe_flash), .i_delay(4'h6), .o_debug_pin(i_debug_pin),
        .o_auth_ok(i_auth_ok), .o_auth_from_debug(i_auth_from_debug),
        .o_wipe_done(i_wipe_done));

    always #20 i_clk = ~i_clk;

    task automatic tally_and_finish;
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic do_reset(input logic [1:0] lvl, input logic sec, input logic key);
        @(negedge i_clk);
        i_ob_level = lvl;
        i_ob_sec_ext_en = sec;
        i_ob_key_configured = key;
        i_reset = 1'b1;
        repeat (20) @(negedge i_clk);
        i_reset = 1'b0;
        repeat (2) @(negedge i_clk);
        `CHK("level", lvl, o_level)
        `CHK("sec_ext", sec, o_sec_ext_en)
    endtask

    task automatic acc(input logic [2:0] ar, input logic [1:0] op, input logic [1:0] mst,
                       input logic sec, input logic [18:0] ad, input logic err);
        integer n;
        @(negedge i_clk);
        {i_req_area, i_req_op, i_req_master, i_req_secure, i_req_addr} = {ar, op, mst, sec, ad};
        i_req_valid = 1'b1;
        n = 0;
        #1;
        while (o_req_ready !== 1'b1 && n < 50) begin
            @(negedge i_clk);
            #1 n++;
        end
        if (n == 50) begin
            error_cnt++;
            tally_and_finish();
        end
        @(negedge i_clk);
        i_req_valid = 1'b0;
        `CHK("resp_valid", 1'b1, o_resp_valid)
        `CHK("resp_error", err, o_resp_error)
    endtask

    task automatic opt(input logic [1:0] lvl, input logic swp, input logic err,
                       input logic wipe);
        integer n;
        logic seen;
        @(negedge i_clk);
        {i_opt_level, i_opt_swap_only, i_opt_swap_val} = {lvl, swp, swp};
        i_opt_start = 1'b1;
        @(negedge i_clk);
        i_opt_start = 1'b0;
        n = 0;
        seen = 1'b0;
        while (o_opt_done !== 1'b1 && o_opt_error !== 1'b1 && n < 50) begin
            seen |= o_wipe_flash & o_wipe_backup & o_wipe_sram;
            @(negedge i_clk);
            n++;
        end
        if (n == 50) begin
            error_cnt++;
            tally_and_finish();
        end
        `CHK("opt_error", err, o_opt_error)
        `CHK("wiped", wipe, seen)
    endtask

    initial begin
        // ---------------------------------------------
        // level 0: fixed areas, one-time area, write protect
        // ---------------------------------------------
        do_reset(`FRP_LVL_0, 0, 0);
        `CHK("prefetch", 1'b0, o_prefetch_en)
        i_prefetch_en = 1'b1;
        for (m = 1; m < 3; m++) acc(`FRP_AREA_SYSMEM, m, 0, 0, 0, 1);
        `CHK("prefetch", 1'b1, o_prefetch_en)
        acc(`FRP_AREA_OPT, `FRP_OP_WRITE, 0, 0, 0, 1);
        `CHK("refused", 1'b1, o_refused)
        i_refused_clear = 1'b1;
        @(negedge i_clk);
        i_refused_clear = 1'b0;
        `CHK("refused", 1'b0, o_refused)
        acc(`FRP_AREA_OTP, `FRP_OP_WRITE, 0, 0, 19'h0_0030, 0);
        acc(`FRP_AREA_OTP, `FRP_OP_WRITE, 0, 0, 19'h0_0030, 1);
        {i_wrp_start, i_wrp_end, i_wrp_en} = {20'h0_0004, 20'h0_0006, 4'h1};
        acc(`FRP_AREA_MAIN, `FRP_OP_ERASE, 0, 0, 19'h0_a000, 1);
        `CHK("page", 5'h5, o_resp_page)
        acc(`FRP_AREA_MAIN, `FRP_OP_ERASE, 0, 0, 19'h0_e000, 0);
        acc(`FRP_AREA_MAIN, `FRP_OP_ERASE, 0, 0, 19'h4_a000, 0);
        `CHK("bank", 1'b1, o_resp_bank)
        // bank 0 busy: bank 0 stalls, bank 1 still served
        i_bank_busy = 2'b01;
        @(negedge i_clk);
        {i_req_area, i_req_addr, i_req_valid} = {`FRP_AREA_MAIN, 19'h0_0000, 1'b1};
        #1 `CHK("ready", 1'b0, o_req_ready)
        @(negedge i_clk);
        i_req_valid = 1'b0;
        acc(`FRP_AREA_MAIN, `FRP_OP_READ, 0, 0, 19'h4_0000, 0);
        i_bank_busy = 2'b00;
        {i_ecc_valid, i_ecc_double, i_ecc_addr} = {1'b1, 1'b1, 19'h1_2340};
        @(negedge i_clk);
        i_ecc_valid = 1'b0;
        `CHK("ecc_double", 1'b1, o_ecc_double)
        `CHK("ecc_addr", 19'h1_2340, o_ecc_fail_addr)
        // single error with a clear in the same cycle: the set wins
        {i_ecc_valid, i_ecc_single, i_ecc_double, i_ecc_clear} = 4'hd;
        @(negedge i_clk);
        {i_ecc_valid, i_ecc_single} = 2'h0;
        `CHK("ecc_single", 1'b1, o_ecc_corrected)
        `CHK("ecc_double", 1'b0, o_ecc_double)
        @(negedge i_clk);
        i_ecc_clear = 1'b0;
        `CHK("ecc_single", 1'b0, o_ecc_corrected)
        opt(`FRP_LVL_05, 0, 1, 0);
        // ---------------------------------------------
        // level 1: foreign masters, password, regression wipe
        // ---------------------------------------------
        i_ob_pwd_required = 1'b1;
        do_reset(`FRP_LVL_1, 0, 0);
        for (m = 1; m < 4; m++) acc(`FRP_AREA_MAIN, `FRP_OP_READ, m, 0, 0, 1);
        acc(`FRP_AREA_MAIN, `FRP_OP_WRITE, 0, 0, 0, 0);
        acc(`FRP_AREA_SYSMEM, `FRP_OP_READ, 1, 0, 0, 0);
        acc(`FRP_AREA_BKPREG, `FRP_OP_WRITE, 1, 0, 0, 1);
        acc(`FRP_AREA_BKPRAM, `FRP_OP_READ, 3, 0, 0, 1);
        acc(`FRP_AREA_BKPRAM, `FRP_OP_WRITE, 0, 0, 0, 0);
        attach = 1'b1;
        repeat (4) @(negedge i_clk);
        acc(`FRP_AREA_MAIN, `FRP_OP_READ, 0, 0, 0, 1);
        attach = 1'b0;
        repeat (4) @(negedge i_clk);
        opt(`FRP_LVL_0, 0, 1, 0);
        pwd = 1'b1;
        opt(`FRP_LVL_0, 0, 0, 1);
        `CHK("level", `FRP_LVL_0, o_level)
        // ---------------------------------------------
        // security extension at levels 1 and 0.5
        // ---------------------------------------------
        {pwd, i_ob_pwd_required} = 2'b00;
        do_reset(`FRP_LVL_1, 1, 0);
        acc(`FRP_AREA_MAIN, `FRP_OP_READ, 1, 0, 0, 0);
        acc(`FRP_AREA_MAIN, `FRP_OP_READ, 2, 0, 0, 1);
        do_reset(`FRP_LVL_05, 1, 0);
        acc(`FRP_AREA_MAIN, `FRP_OP_READ, 1, 1, 0, 1);
        acc(`FRP_AREA_MAIN, `FRP_OP_READ, 1, 0, 0, 0);
        // ---------------------------------------------
        // level 2 without and with a key
        // ---------------------------------------------
        do_reset(`FRP_LVL_2, 0, 0);
        `CHK("debug_enable", 1'b0, o_debug_enable)
        acc(`FRP_AREA_SYSMEM, `FRP_OP_READ, 1, 0, 0, 1);
        acc(`FRP_AREA_MAIN, `FRP_OP_READ, 0, 0, 0, 0);
        {attach, pwd} = 2'b11;
        repeat (4) @(negedge i_clk);
        // debug port is shut at level 2: the application keeps its flash
        acc(`FRP_AREA_MAIN, `FRP_OP_READ, 0, 0, 0, 0);
        opt(`FRP_LVL_1, 0, 1, 0);
        opt(`FRP_LVL_2, 1, 0, 0);
        `CHK("swap", 1'b1, o_swap_bank)
        opt(`FRP_LVL_2, 0, 1, 0);
        attach = 1'b0;
        do_reset(`FRP_LVL_2, 0, 1);
        opt(`FRP_LVL_1, 0, 1, 0);
        attach = 1'b1;
        repeat (4) @(negedge i_clk);
        opt(`FRP_LVL_1, 0, 0, 0);
        `CHK("level", `FRP_LVL_1, o_level)
        tally_and_finish();
    end
endmodule // frp_policy_tb
